// [design/rcd_pkg.sv]
// Shared constants, types and call/answer carriers for the rate conversion and delay block
package rcd_pkg;
   // Data path width and fixed geometry of every primitive state
   localparam int DW = 16;
   localparam int K_RATIO = 4;            // Audio samples per control period
   localparam int WIN_MAX = 8;            // Longest interpolation window held
   localparam int FD_MAX = 16;            // Fractional line entries, index 0..FD_MAX-1
   localparam int DLY_LEN = 8;            // Fixed delay, in calls
   localparam int FRAC_W = 4;             // Fraction bits of position_arg, in samples
   localparam int WIN_SH = 14;            // Window coefficients are Q2.14
   localparam int MEAN_SH = 2;            // log2 of K_RATIO
   localparam int ERR_W = 8;
   localparam logic [3:0] K_LEN = 4'h4;
   localparam logic [3:0] FD_LAST = 4'hf;
   localparam logic signed [DW-1:0] WIN_ONE = 16'h4000;
   localparam logic signed [DW-1:0] SMP_ZERO = 16'h0000;
   localparam logic [ERR_W-1:0] ERR_RST = 8'h00;

   // Method codes of the fractional delay line
   localparam logic [2:0] M_INIT = 3'h1;
   localparam logic [2:0] M_TAP = 3'h2;
   localparam logic [2:0] M_SET = 3'h3;
   localparam logic [2:0] M_ADD = 3'h4;
   localparam logic [2:0] M_SHIFT = 3'h5;

   // Primitive selector; its position also names the error flag bit
   typedef enum logic [2:0] {
      P_DECIM, P_UPSAMP, P_DOWNSAMP, P_HOLD, P_SBLOCK, P_DELAY, P_SINGLE_SAMPLE_DELAY, P_FRAC
   } rcd_prim_e;

   typedef logic signed [DW-1:0] rcd_smp_t;
   typedef rcd_smp_t [WIN_MAX-1:0] rcd_win_t;
   typedef rcd_smp_t [K_RATIO-1:0] rcd_blk_t;

   // One audio-rate call from the engine
   typedef struct packed {
      logic valid;
      rcd_prim_e prim;
      logic [2:0] method;
      rcd_smp_t x;
      rcd_smp_t gate;
      rcd_smp_t position_arg;
      rcd_smp_t value_arg;
      logic has_pos;
      logic has_val;
   } rcd_call_s;

   // Control-rate answers produced at each period boundary
   typedef struct packed {
      logic valid;
      rcd_smp_t decim;
      rcd_smp_t downsamp;
   } rcd_kout_s;
endpackage

// [design/rcd_fixed_delay.sv]
// Fixed-length call-counted delay used by the rate conversion block
`timescale 1ns/10ps
`default_nettype none
module rcd_fixed_delay
   import rcd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic push_i,
   input wire rcd_smp_t din_i,
   output rcd_smp_t tail_o
);
   rcd_smp_t mem_r [DLY_LEN];

   // Shift on every push only; time is counted in calls, so two calls per sample halve it
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < DLY_LEN; i++) begin
            mem_r[i] <= SMP_ZERO;
         end
      end else if (push_i) begin
         mem_r[0] <= din_i;
         for (int i = 1; i < DLY_LEN; i++) begin
            mem_r[i] <= mem_r[i-1];
         end
      end
   end

   // Oldest entry is the one pushed DLY_LEN calls ago
   assign tail_o = mem_r[DLY_LEN-1];
endmodule // rcd_fixed_delay
`default_nettype wire

// [design/rcd_rate_delay.sv]
// Rate conversion, sample-and-hold, block capture and delay line primitives
`timescale 1ns/10ps
`default_nettype none
module rcd_rate_delay
   import rcd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire rcd_call_s call_i,
   input wire logic kbound_i,
   input wire rcd_win_t win_i,
   input wire logic [3:0] win_len_i,
   input wire logic up_win_en_i,
   input wire logic dn_win_en_i,
   input wire logic [7:0] tbl_size_i,
   input wire logic [ERR_W-1:0] err_clr_i,
   output rcd_smp_t result_o,
   output logic result_valid_o,
   output rcd_kout_s kout_o,
   output rcd_blk_t sblk_tbl_o,
   output logic sblk_wr_o,
   output logic [ERR_W-1:0] err_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Shared arithmetic
   function automatic rcd_smp_t mulq(input rcd_smp_t a, input rcd_smp_t b);
      logic signed [2*DW-1:0] p;
      p = a * b;
      return rcd_smp_t'(p >>> WIN_SH);
   endfunction

   function automatic logic is_call(input rcd_call_s c, input rcd_prim_e p);
      return c.valid && (c.prim == p);
   endfunction

   rcd_smp_t result_r, res_nxt, dec_last_r, hold_r, d1_r, dly_tail;
   logic result_valid_r, sblk_wr_r;
   rcd_kout_s kout_r;
   rcd_blk_t sblk_tbl_r;
   logic [ERR_W-1:0] err_r, err_set;
   rcd_smp_t up_buf_r [WIN_MAX];
   rcd_smp_t up_new [WIN_MAX];
   logic [3:0] up_ptr_r, up_len;
   logic up_fresh_r, up_kfirst_r, up_kf;
   rcd_smp_t dn_buf_r [K_RATIO];
   rcd_smp_t sb_buf_r [K_RATIO];
   logic signed [DW+2:0] dn_sum, dn_wsum;
   rcd_smp_t fd_line_r [FD_MAX];
   logic [3:0] fd_len_r;
   logic fd_init_r, fd_bad, fd_oor;
   logic [DW-FRAC_W-1:0] fd_int;
   logic [3:0] fd_idx;
   rcd_smp_t fd_a, fd_b, fd_res;
   logic signed [DW:0] fd_diff;
   logic signed [DW+FRAC_W+1:0] fd_prod;

   ////////////////////////////////////////////////////////////////////////////
   // Decimator: remember the last input, publish it at the boundary
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         dec_last_r <= SMP_ZERO;
      end else if (is_call(call_i, P_DECIM)) begin
         dec_last_r <= call_i.x;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Upsampler: effective window and shifted-plus-scaled buffer image
   always_comb begin
      up_len = (up_win_en_i && (win_len_i > K_LEN)) ? win_len_i : K_LEN;
      up_kf = up_fresh_r | up_kfirst_r | kbound_i;
      for (int i = 0; i < WIN_MAX; i++) begin
         rcd_smp_t wv;
         rcd_smp_t sh;
         wv = SMP_ZERO;
         sh = SMP_ZERO;
         if (!up_win_en_i) begin
            wv = (i < K_RATIO) ? WIN_ONE : SMP_ZERO;
         end else if (4'(i) < win_len_i) begin
            wv = win_i[i]; // Zero padding beyond the supplied length
         end
         if (!up_fresh_r && (i + K_RATIO < WIN_MAX) && (4'(i + K_RATIO) < up_len)) begin
            sh = up_buf_r[(i + K_RATIO) % WIN_MAX];
         end
         up_new[i] = sh + mulq(call_i.x, wv);
      end
   end

   // Buffer and pointer; a call in the boundary cycle counts as the first of the new period
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         up_fresh_r <= 1'b1;
         up_kfirst_r <= 1'b1;
         up_ptr_r <= 4'h0;
         for (int i = 0; i < WIN_MAX; i++) begin
            up_buf_r[i] <= SMP_ZERO;
         end
      end else begin
         if (kbound_i) begin
            up_kfirst_r <= 1'b1;
         end
         if (is_call(call_i, P_UPSAMP)) begin
            up_fresh_r <= 1'b0;
            if (up_kf) begin
               up_kfirst_r <= 1'b0;
               up_buf_r <= up_new;
               up_ptr_r <= 4'h1; // Reset to zero, then advanced past entry 0
            end else if (up_ptr_r < up_len) begin
               up_ptr_r <= up_ptr_r + 4'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Downsampler and block capture share the same last-K shift structure
   always_comb begin
      dn_sum = '0;
      dn_wsum = '0;
      for (int i = 0; i < K_RATIO; i++) begin
         dn_sum = dn_sum + (DW+3)'(dn_buf_r[i]);
         dn_wsum = dn_wsum + (DW+3)'(mulq(dn_buf_r[i], win_i[i]));
      end
   end

   // Newest sample lands at the top, so extra calls push old ones out
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < K_RATIO; i++) begin
            dn_buf_r[i] <= SMP_ZERO;
            sb_buf_r[i] <= SMP_ZERO;
         end
      end else begin
         if (is_call(call_i, P_DOWNSAMP)) begin
            dn_buf_r[K_RATIO-1] <= call_i.x;
            for (int i = 0; i < K_RATIO - 1; i++) begin
               dn_buf_r[i] <= dn_buf_r[i+1];
            end
         end
         if (is_call(call_i, P_SBLOCK)) begin
            sb_buf_r[K_RATIO-1] <= call_i.x;
            for (int i = 0; i < K_RATIO - 1; i++) begin
               sb_buf_r[i] <= sb_buf_r[i+1];
            end
         end
      end
   end

   // Boundary answers; a call in the boundary cycle belongs to the next period
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         kout_r <= '0;
         sblk_wr_r <= 1'b0;
         sblk_tbl_r <= '0;
      end else begin
         kout_r.valid <= kbound_i;
         sblk_wr_r <= kbound_i && (tbl_size_i >= 8'(K_RATIO));
         if (kbound_i) begin
            kout_r.decim <= dec_last_r;
            kout_r.downsamp <= dn_win_en_i ? rcd_smp_t'(dn_wsum)
                                           : rcd_smp_t'(dn_sum >>> MEAN_SH);
            for (int i = 0; i < K_RATIO; i++) begin
               sblk_tbl_r[i] <= sb_buf_r[i]; // Oldest at index 0
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sample-and-hold and single-sample delay
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         hold_r <= SMP_ZERO;
         d1_r <= SMP_ZERO;
      end else begin
         if (is_call(call_i, P_HOLD) && (call_i.gate != SMP_ZERO)) begin
            hold_r <= call_i.x;
         end
         if (is_call(call_i, P_SINGLE_SAMPLE_DELAY)) begin
            d1_r <= call_i.x;
         end
      end
   end

   // Fixed delay: the shift register pushes only on its own calls
   rcd_fixed_delay u_fixed_delay (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .push_i(is_call(call_i, P_DELAY)),
      .din_i(call_i.x),
      .tail_o(dly_tail)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Fractional line: positions are in samples, FRAC_W fraction bits
   always_comb begin
      fd_int = call_i.position_arg[DW-1:FRAC_W];
      fd_idx = fd_int[3:0];
      fd_oor = !call_i.has_pos || call_i.position_arg[DW-1] ||
               (fd_int > (DW-FRAC_W)'(fd_len_r)) ||
               ((fd_int == (DW-FRAC_W)'(fd_len_r)) &&
                (call_i.position_arg[FRAC_W-1:0] != '0)); // Past the end by a fraction
      fd_a = fd_line_r[fd_idx];
      fd_b = (fd_idx < fd_len_r) ? fd_line_r[fd_idx + 4'h1] : fd_a;
      fd_diff = (DW+1)'(fd_b) - (DW+1)'(fd_a);
      fd_prod = fd_diff * $signed({1'b0, call_i.position_arg[FRAC_W-1:0]});
      fd_res = SMP_ZERO;
      fd_bad = 1'b0;
      case (call_i.method)
         M_INIT: begin
            fd_bad = !call_i.has_pos || call_i.position_arg[DW-1] ||
                     (fd_int > (DW-FRAC_W)'(FD_LAST));
         end
         M_TAP: begin
            fd_bad = !fd_init_r || fd_oor;
            fd_res = fd_a + rcd_smp_t'(fd_prod >>> FRAC_W); // Linear interpolation
         end
         M_SET: begin
            fd_bad = !fd_init_r || fd_oor || !call_i.has_val;
         end
         M_ADD: begin
            fd_bad = !fd_init_r || !call_i.has_val || fd_oor;
            fd_res = fd_a + call_i.value_arg;
         end
         M_SHIFT: begin
            fd_bad = !fd_init_r;
            fd_res = fd_line_r[fd_len_r];
         end
         default: begin
            fd_bad = 1'b1;
         end
      endcase
   end

   // A rejected call leaves the line untouched, so a bad index never writes
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fd_init_r <= 1'b0;
         fd_len_r <= 4'h0;
         for (int i = 0; i < FD_MAX; i++) begin
            fd_line_r[i] <= SMP_ZERO;
         end
      end else if (is_call(call_i, P_FRAC) && !fd_bad) begin
         case (call_i.method)
            M_INIT: begin
               fd_init_r <= 1'b1;
               fd_len_r <= fd_idx;
               for (int i = 0; i < FD_MAX; i++) begin
                  fd_line_r[i] <= SMP_ZERO;
               end
            end
            M_SET: fd_line_r[fd_idx] <= call_i.value_arg;
            M_ADD: fd_line_r[fd_idx] <= fd_res;
            M_SHIFT: begin
               fd_line_r[0] <= SMP_ZERO;
               for (int i = 1; i < FD_MAX; i++) begin
                  fd_line_r[i] <= fd_line_r[i-1];
               end
            end
            default: fd_len_r <= fd_len_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Call answer mux and error detection
   always_comb begin
      res_nxt = SMP_ZERO;
      err_set = '0;
      if (call_i.valid) begin
         case (call_i.prim)
            P_UPSAMP: begin
               res_nxt = up_kf ? up_new[0]
                               : ((up_ptr_r < up_len) ? up_buf_r[up_ptr_r[2:0]] : SMP_ZERO);
               err_set[P_UPSAMP] = !up_kf && (up_ptr_r >= up_len);
            end
            P_DOWNSAMP: err_set[P_DOWNSAMP] = dn_win_en_i && (win_len_i < K_LEN);
            P_HOLD: res_nxt = (call_i.gate != SMP_ZERO) ? call_i.x : hold_r;
            P_SBLOCK: res_nxt = SMP_ZERO;
            P_DELAY: res_nxt = dly_tail;
            P_SINGLE_SAMPLE_DELAY: res_nxt = d1_r;
            P_FRAC: begin
               res_nxt = fd_bad ? SMP_ZERO : fd_res;
               err_set[P_FRAC] = fd_bad;
            end
            default: res_nxt = SMP_ZERO;
         endcase
      end
      if (kbound_i && (tbl_size_i < 8'(K_RATIO))) begin
         err_set[P_SBLOCK] = 1'b1;
      end
   end

   // Answer registers; a new error wins over a clear in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         result_r <= SMP_ZERO;
         result_valid_r <= 1'b0;
         err_r <= ERR_RST;
      end else begin
         result_r <= res_nxt;
         result_valid_r <= call_i.valid;
         err_r <= (err_r & ~err_clr_i) | err_set;
      end
   end

   assign result_o = result_r;
   assign result_valid_o = result_valid_r;
   assign kout_o = kout_r;
   assign sblk_tbl_o = sblk_tbl_r;
   assign sblk_wr_o = sblk_wr_r;
   assign err_o = err_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_frac_call(logic [2:0] m);
      call_i.valid && (call_i.prim == P_FRAC) && (call_i.method == m);
   endsequence
   sequence s_up_first;
      is_call(call_i, P_UPSAMP) && up_kf;
   endsequence

   AST_DEC_BOUNDARY: assert property (kbound_i |=> kout_o.valid &&
      (kout_o.decim == $past(dec_last_r))) else $error("decimator output wrong");
   AST_UP_FIRST: assert property (s_up_first ##1 is_call(call_i, P_UPSAMP) |->
      !kbound_i && !up_fresh_r ##1 result_o == $past(up_buf_r[1]))
      else $error("second upsampler call did not return entry one");
   AST_UP_ERR: assert property (is_call(call_i, P_UPSAMP) && !up_kf && up_ptr_r >= up_len
      |=> err_o[P_UPSAMP]) else $error("upsampler overrun not flagged");
   AST_MEAN: assert property (kbound_i && !dn_win_en_i |=>
      kout_o.downsamp == rcd_smp_t'($past(dn_sum) >>> MEAN_SH)) else $error("mean wrong");
   AST_HOLD: assert property (is_call(call_i, P_HOLD) && call_i.gate == SMP_ZERO
      |=> result_o == $past(hold_r)) else $error("hold value changed with zero gate");
   AST_SBLK_ZERO: assert property (is_call(call_i, P_SBLOCK) |=>
      result_valid_o && result_o == SMP_ZERO) else $error("capture call returned nonzero");
   AST_SBLK_SMALL: assert property (kbound_i && tbl_size_i < 8'(K_RATIO) |=>
      err_o[P_SBLOCK] && !sblk_wr_o) else $error("small table not flagged");
   AST_BAD_METHOD: assert property ((s_frac_call(3'h0) or s_frac_call(3'h6) or
      s_frac_call(3'h7)) |=> err_o[P_FRAC]) else $error("bad method not flagged");
   AST_UNINIT: assert property (s_frac_call(M_SHIFT) and !fd_init_r |=>
      err_o[P_FRAC] && result_o == SMP_ZERO) else $error("uninitialised line not flagged");
   AST_STICKY: assert property (err_o[P_FRAC] && !err_clr_i[P_FRAC] |=>
      err_o[P_FRAC]) else $error("error flag dropped without clear");
endmodule // rcd_rate_delay
`default_nettype wire

// [verif/rcd_engine.sv]
// Engine model that issues audio-rate calls, control boundaries and flag clears
`timescale 1ns/10ps
`default_nettype none
module rcd_engine
   import rcd_pkg::*;
(
   input wire logic ref_clk_i,
   output rcd_call_s call_o,
   output logic kbound_o,
   output logic [ERR_W-1:0] err_clr_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Quiet at time zero so that nothing is taken during reset
   initial begin
      call_o = '0;
      kbound_o = 1'b0;
      err_clr_o = ERR_RST;
   end
   // Every task starts and ends at a falling edge, so a request stands over one rising edge
   // Codes outside 1 to 5 and methods before initialise go out only when a scenario asks
   task automatic call(input rcd_call_s c);
      call_o = c;
      @(negedge ref_clk_i);
   endtask
   // A slow engine leaves gaps; the released fields are inverted, so a second gap in a row restores the last call's fields with valid still low
   task automatic idle();
      call_o = {1'b0, ~call_o[$bits(call_o)-2:0]};
      @(negedge ref_clk_i);
   endtask
   // Boundary pulse with no call in the same cycle
   task automatic bound();
      call_o = {1'b0, ~call_o[$bits(call_o)-2:0]};
      kbound_o = 1'b1;
      @(negedge ref_clk_i);
      kbound_o = 1'b0;
   endtask
   // Clear mask held for one rising edge
   task automatic clear(input logic [ERR_W-1:0] m);
      call_o = {1'b0, ~call_o[$bits(call_o)-2:0]};
      err_clr_o = m;
      @(negedge ref_clk_i);
      err_clr_o = ERR_RST;
   endtask
endmodule // rcd_engine
`default_nettype wire

// [verif/rate_conversion_and_delay_lines_test.sv]
// Self-checking bench: behavioural model of every primitive compared at each result
`timescale 1ns/10ps
`default_nettype none
module rate_conversion_and_delay_lines_test
   import rcd_pkg::*;
;
   logic ref_clk_i, rst_i, kb, up_en, dn_en, rv, wr;
   rcd_call_s call;
   rcd_win_t win;
   logic [3:0] win_len;
   logic [7:0] tbl;
   logic [ERR_W-1:0] clr, err, eexp;
   rcd_smp_t result;
   rcd_kout_s kout;
   rcd_blk_t tblo;
   integer seed = 26;
   int errors = 0, total_checks = 0, d1 = 0, hold = 0, dl = 0, ptr = 0, first = 0;
   int flen = 0, finit = 0, k, i, x;
   int fq[$];
   int ds[$];
   int sb[$];
   int line[16];
   int upb[8];
   int te[4];
   int ms[5] = '{0, 6, 7, 2, 5};
   int op[14][4] = '{'{1, -16, 0, 0}, '{1, 256, 0, 0}, '{1, 48, 0, 0}, '{3, 16, 100, 1},
      '{3, 24, 7, 0}, '{2, 24, 0, 0}, '{4, 16, 6, 1}, '{2, 64, 0, 0}, '{3, 56, 1, 1},
      '{5, 0, 0, 0}, '{5, 0, 0, 0}, '{5, 0, 0, 0}, '{1, 240, 0, 0}, '{5, 0, 0, 0}};
   rcd_prim_e pl[3] = '{P_SINGLE_SAMPLE_DELAY, P_DELAY, P_HOLD};

   ////////////////////////////////////////////////////////////////////////////////
   rcd_engine eng (.ref_clk_i(ref_clk_i), .call_o(call), .kbound_o(kb), .err_clr_o(clr));
   rcd_rate_delay dut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .call_i(call), .kbound_i(kb), .win_i(win),
      .win_len_i(win_len), .up_win_en_i(up_en), .dn_win_en_i(dn_en), .tbl_size_i(tbl),
      .err_clr_i(clr), .result_o(result), .result_valid_o(rv), .kout_o(kout),
      .sblk_tbl_o(tblo), .sblk_wr_o(wr), .err_o(err)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Free-running 100 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // Watchdog: a run that overstays its cycle budget is cut short
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      errors++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One comparison; case inequality so an unknown never passes
   task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] s);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Model one call, issue it, then compare answer and flags one cycle later
   task automatic go(input rcd_prim_e p, input logic [2:0] m, input int x, input int g,
                     input int pos, input int v, input logic hv);
      int e, j, n, bad, ix;
      logic skip;
      e = 0;
      skip = 1'b0;
      n = (up_en && win_len > 4'h4) ? int'(win_len) : 4;
      ix = pos >>> 4;
      case (p)
         P_SINGLE_SAMPLE_DELAY: begin
            e = d1;
            d1 = x;
         end
         P_DELAY: begin
            fq.push_back(x);
            e = fq.pop_front();
         end
         P_HOLD: begin
            if (g != 0) hold = x;
            e = hold;
         end
         P_DECIM: begin
            dl = x;
            skip = 1'b1;
         end
         P_DOWNSAMP: begin
            ds.push_back(x);
            void'(ds.pop_front());
            skip = 1'b1;
         end
         P_SBLOCK: begin
            sb.push_back(x);
            void'(sb.pop_front());
         end
         P_UPSAMP: begin
            // The window is applied once per period, on its first call
            if (first) begin
               for (j = 0; j < 8; j++) upb[j] = (j + 4 < n) ? upb[j + 4] : 0;
               for (j = 0; j < n; j++) upb[j] += (x * (up_en ? (j < win_len ? int'(win[j]) : 0)
                  : int'(WIN_ONE))) >>> 14;
               ptr = 0;
               first = 0;
            end
            if (ptr >= n) begin
               eexp[P_UPSAMP] = 1'b1;
               skip = 1'b1;
            end else begin
               e = upb[ptr];
               ptr++;
            end
         end
         default: begin
            if (m == M_INIT) bad = pos < 0 || ix > 15;
            else if (m < M_TAP || m > M_SHIFT || !finit) bad = 1;
            else bad = m != M_SHIFT && (pos < 0 || pos > 16 * flen || (m != M_TAP && !hv));
            if (bad) eexp[P_FRAC] = 1'b1;
            else if (m == M_INIT) begin
               flen = ix;
               finit = 1;
               line = '{default: 0};
            end else if (m == M_TAP) begin
               e = (line[ix] * (16 - pos % 16) + line[ix + (ix < flen)] * (pos % 16)) >>> 4;
            end else if (m == M_SET) line[ix] = v;
            else if (m == M_ADD) begin
               line[ix] += v;
               e = line[ix];
            end else begin
               e = line[flen];
               for (j = flen; j > 0; j--) line[j] = line[j - 1];
               line[0] = 0;
            end
         end
      endcase
      eng.call('{1'b1, p, m, DW'(x), DW'(g), DW'(pos), DW'(v), 1'b1, hv});
      chk("valid", DW'(1), DW'(rv));
      if (!skip) chk("result", DW'(e), result);
      chk("err", DW'(eexp), DW'(err));
   endtask
   // Model one boundary, pulse it, then compare the control-rate answers
   task automatic bnd();
      int s, j;
      s = 0;
      // Each windowed product is scaled on its own, as the hardware does
      for (j = 0; j < 4; j++) s += dn_en ? (ds[j] * int'(win[j])) >>> 14 : ds[j];
      // The table image follows every boundary; only the write strobe is withheld
      foreach (te[j]) te[j] = sb[j];
      if (tbl < 8'h04) eexp[P_SBLOCK] = 1'b1;
      first = 1;
      eng.bound();
      chk("kvalid", DW'(1), DW'(kout.valid));
      chk("decim", DW'(dl), kout.decim);
      chk("downsamp", DW'(dn_en ? s : s >>> 2), kout.downsamp);
      chk("write", DW'(tbl >= 8'h04), DW'(wr));
      foreach (te[j]) chk("table", DW'(te[j]), tblo[j]);
      chk("err", DW'(eexp), DW'(err));
   endtask
   // Report counts, print the verdict and stop
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_i = 1'b1;
      // Random coefficients so both windowed paths see more than a boxcar
      for (k = 0; k < WIN_MAX; k++) win[k] = DW'($random(seed) % 16384);
      win_len = K_LEN;
      up_en = 1'b0;
      dn_en = 1'b0;
      tbl = 8'h04;
      eexp = ERR_RST;
      for (k = 0; k < 8; k++) fq.push_back(0);
      for (k = 0; k < 4; k++) ds.push_back(0);
      for (k = 0; k < 4; k++) sb.push_back(0);
      repeat (20) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk("err", DW'(ERR_RST), DW'(err));
      chk("kvalid", DW'(0), DW'(kout.valid | rv | wr));
      // Random per-call traffic; idle gaps show that delays count calls, not time
      repeat (60) begin
         k = $unsigned($random(seed)) % 3;
         x = $random(seed) % 100;
         go(pl[k], 3'h0, x, $random(seed) & 1, 0, 0, 1'b0);
         if ($random(seed) & 1) eng.idle();
      end
      // Three periods: doubled calls, then windowed sum, then a too-short capture table
      bnd();
      for (k = 0; k < 3; k++) begin
         dn_en = (k == 1);
         tbl = (k == 2) ? 8'h03 : 8'h04 + 8'($unsigned($random(seed)) % 200);
         for (i = 0; i < (k == 0 ? 8 : 4); i++) begin
            x = 4 * i + 4 + k;
            go(P_DECIM, 3'h0, x, 0, 0, 0, 1'b0);
            go(P_DOWNSAMP, 3'h0, x, 0, 0, 0, 1'b0);
            go(P_SBLOCK, 3'h0, x, 0, 0, 0, 1'b0);
            if (i < 4) go(P_UPSAMP, 3'h0, 10 * k + 5, 0, 0, 0, 1'b0);
         end
         bnd();
      end
      // Long window: eight calls fit a period, a ninth overflows
      up_en = 1'b1;
      win_len = 4'h8;
      for (k = 0; k < 2; k++) begin
         for (i = 0; i < 8 + k; i++) go(P_UPSAMP, 3'h0, 20 - 17 * k, 0, 0, 0, 1'b0);
         bnd();
      end
      // Flags stay until cleared, one bit at a time or all together
      eng.clear(8'h10);
      eexp[P_SBLOCK] = 1'b0;
      chk("err", DW'(eexp), DW'(err));
      eng.clear(8'hff);
      eexp = ERR_RST;
      chk("err", DW'(eexp), DW'(err));
      // Fractional line: bad codes and use before initialise, then a directed walk
      for (i = 0; i < 5; i++) go(P_FRAC, 3'(ms[i]), 0, 0, 16, 1, 1'b1);
      for (k = 0; k < 14; k++) begin
         go(P_FRAC, 3'(op[k][0]), 0, 0, op[k][1], op[k][2], op[k][3] != 0);
      end
      repeat (30) begin
         k = 2 + $unsigned($random(seed)) % 4;
         x = 16 * ($unsigned($random(seed)) % 4);
         go(P_FRAC, 3'(k), 0, 0, x, $random(seed) % 50, 1'b1);
      end
      eng.clear(8'hff);
      eexp = ERR_RST;
      chk("err", DW'(eexp), DW'(err));
      end_of_test();
   end
endmodule // rate_conversion_and_delay_lines_test
`default_nettype wire
